// >>> design/rtc_pkg.sv
// constants shared by the real-time clock core
package rtc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_TIME  = 8'h00;
  localparam logic [7:0] OFS_DATE  = 8'h04;
  localparam logic [7:0] OFS_SUBS  = 8'h08;
  localparam logic [7:0] OFS_CTRL  = 8'h0c;
  localparam logic [7:0] OFS_STAT  = 8'h10;
  localparam logic [7:0] OFS_PRE   = 8'h14;
  localparam logic [7:0] OFS_ALM   = 8'h18;
  localparam logic [7:0] OFS_ALMSS = 8'h1c;
  localparam logic [7:0] OFS_WUT   = 8'h20;
  localparam logic [7:0] OFS_KEY   = 8'h24;
  // control register bit positions
  localparam int C_INIT  = 0;
  localparam int C_BYP   = 1;
  localparam int C_SYNC_BYPASS_BIT_A = 2;
  localparam int C_FMT   = 3;
  localparam int C_ALE   = 4;
  localparam int C_ALIE  = 5;
  localparam int C_WUE   = 6;
  localparam int C_WUIE  = 7;
  localparam int C_WSEL  = 8;
  localparam int C_OSEL  = 11;
  localparam int C_POL   = 13;
  localparam int C_SUBTRACT_HOUR_BIT = 14;
  localparam int C_ADD_HOUR_BIT = 15;
  localparam int C_BCK   = 16;
  // status register bit positions
  localparam int S_ALF  = 0;
  localparam int S_WUF  = 1;
  localparam int S_RSF  = 2;
  localparam int S_INF  = 3;
  localparam int S_INS  = 4;
  localparam int S_ALWF = 5;
  localparam int S_WUWF = 6;
  // alarm mask bits in the alarm subsecond word
  localparam int M_SEC = 16;
  localparam int M_SS  = 20;
  // reset values, key bytes and load delay count
  localparam logic [6:0]  ADIV_RST = 7'h7f;
  localparam logic [14:0] SDIV_RST = 15'h00ff;
  localparam logic [7:0]  KEY_1    = 8'hca;
  localparam logic [7:0]  KEY_2    = 8'h53;
  localparam logic [2:0]  LOAD_CYC = 3'h4;
  // pin output select codes
  localparam logic [1:0] OSEL_ALM = 2'h1;
  localparam logic [1:0] OSEL_WUT = 2'h3;
  typedef enum logic [1:0] {ST_RUN, ST_INIT, ST_LOAD} rtc_init_e;
endpackage

// >>> design/rtc_core.sv
// real-time clock core: prescaler, calendar, alarm, wakeup, apb
`timescale 1ns/100ps
`default_nettype none
module rtc_core (
  input  wire logic        pclk,             // system bus clock
  input  wire logic        presetn,          // power-on reset, low
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb enable
  input  wire logic        pwrite,           // apb write
  input  wire logic [7:0]  paddr,            // apb byte address
  input  wire logic [31:0] pwdata,           // apb write data
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error
  input  wire logic        rtc_kernel_clock, // kernel clock pin
  input  wire logic        sys_reset_n,      // system reset pin, low
  input  wire logic        active_halt,      // low-power halt state
  output logic             alarm_pin,        // alarm output pin
  output logic             alarm_irq,        // alarm wake request
  output logic             wakeup_irq        // wakeup wake request
);
  import rtc_pkg::*;

  // pin synchronisers: three flops, a change counts when 2 and 3 agree
  logic [2:0] pin_in;
  logic [2:0] s1_q, s2_q, s3_q, filt_q;
  assign pin_in = {active_halt, sys_reset_n, rtc_kernel_clock};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s1_q[gi]   <= 1'b0;
          s2_q[gi]   <= 1'b0;
          s3_q[gi]   <= 1'b0;
          filt_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi] <= pin_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            filt_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  logic [16:0] ctrl_q;            // control register
  logic        kt;                // one kernel tick
  logic        halt;              // active halt level
  logic        sys_rst;           // system reset level
  assign halt    = filt_q[2];
  assign sys_rst = !filt_q[1];
  // kernel edge once stages 2 and 3 agree high and the level was low;
  // sync_bypass_bit_a mode skips the synchroniser, every bus clock is a tick
  assign kt = ctrl_q[C_SYNC_BYPASS_BIT_A] ? 1'b1
            : (s2_q[0] & s3_q[0] & ~filt_q[0]);

  // apb handshake: one wait state, write lands on completion edge
  logic acc, wr;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  assign acc = psel & penable & ~pready_q;
  assign wr  = psel & penable & pready_q & pwrite;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // write lock: two-key sequence
  logic key1_q, unlk_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key1_q <= 1'b0;
      unlk_q <= 1'b0;
    end
    else if (wr && paddr == OFS_KEY)
    begin
      // any other byte relocks, so a stray write cannot open it
      key1_q <= (pwdata[7:0] == KEY_1);
      unlk_q <= key1_q && (pwdata[7:0] == KEY_2);
    end
  end

  // kernel-side copies of control bits, two kernel ticks late
  logic [2:0] k1_q, k2_q, k3_q;  // {wut_en, alarm_en, init}
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      k1_q <= 3'h0;
      k2_q <= 3'h0;
      k3_q <= 3'h0;
    end
    else if (kt)
    begin
      k1_q <= {ctrl_q[C_WUE], ctrl_q[C_ALE], ctrl_q[C_INIT]};
      k2_q <= k1_q;
      k3_q <= k2_q;
    end
  end

  // init state machine
  rtc_init_e st_q;
  logic [2:0] ld_q;              // load delay count
  logic       init_act;
  assign init_act = (st_q == ST_INIT);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_RUN;
      ld_q <= 3'h0;
    end
    else
    begin
      case (st_q)
        ST_RUN:
          if (k2_q[0])
            st_q <= ST_INIT;
        ST_INIT:
          if (!k2_q[0])
          begin
            st_q <= ST_LOAD;
            ld_q <= 3'h0;
          end
        ST_LOAD:
          if (kt)
          begin
            ld_q <= ld_q + 3'h1;
            if (ld_q == LOAD_CYC - 3'h1)
              st_q <= ST_RUN;
          end
        default:
          st_q <= ST_RUN;
      endcase
    end
  end

  // prescaler settings and counters
  logic [6:0]  adiv_q, acnt_q;
  logic [14:0] sdiv_q, scnt_q;
  logic        apre, spre, run;
  assign run  = (st_q == ST_RUN);
  assign apre = kt & run & (acnt_q == 7'h0);
  assign spre = apre & (scnt_q == 15'h0);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adiv_q <= ADIV_RST;
      sdiv_q <= SDIV_RST;
    end
    else if (wr && paddr == OFS_PRE && unlk_q && init_act)
    begin
      adiv_q <= pwdata[6:0];
      sdiv_q <= pwdata[30:16];
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acnt_q <= ADIV_RST;
      scnt_q <= SDIV_RST;
    end
    else if (!run)
    begin
      // held reloaded so a full second follows the init exit
      acnt_q <= adiv_q;
      scnt_q <= sdiv_q;
    end
    else if (kt)
    begin
      acnt_q <= (acnt_q == 7'h0) ? adiv_q : acnt_q - 7'h1;
      if (apre)
        scnt_q <= (scnt_q == 15'h0) ? sdiv_q : scnt_q - 15'h1;
    end
  end

  // bcd helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0}
                               : {v[7:4], v[3:0] + 4'h1};
  endfunction
  function automatic logic [7:0] bcd_dec(input logic [7:0] v);
    bcd_dec = (v[3:0] == 4'h0) ? {v[7:4] - 4'h1, 4'h9}
                               : {v[7:4], v[3:0] - 4'h1};
  endfunction
  // last day of month, leap when the bcd year divides by four
  function automatic logic [5:0] last_day(input logic [4:0] m,
                                          input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                   y[3:0] == 4'h8);
    if (m == 5'h02)
      last_day = leap ? 6'h29 : 6'h28;
    else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11)
      last_day = 6'h30;
    else
      last_day = 6'h31;
  endfunction

  // calendar counters, reset by power-on only
  logic [6:0] sec_q, min_q;
  logic [5:0] hr_q, date_q;
  logic [4:0] mon_q;
  logic [2:0] wday_q;
  logic [7:0] yr_q;
  logic [7:0] hr_up, hr_dn;
  assign hr_up = bcd_inc({2'b0, hr_q});
  assign hr_dn = bcd_dec({2'b0, hr_q});
  // next bcd value of each field, cut to the field width below
  logic [7:0] sec_up, min_up, date_up, mon_up;
  assign sec_up  = bcd_inc({1'b0, sec_q});
  assign min_up  = bcd_inc({1'b0, min_q});
  assign date_up = bcd_inc({2'b0, date_q});
  assign mon_up  = bcd_inc({3'b0, mon_q});
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_q  <= 7'h0;
      min_q  <= 7'h0;
      hr_q   <= 6'h0;
      date_q <= 6'h01;
      mon_q  <= 5'h01;
      wday_q <= 3'h1;
      yr_q   <= 8'h0;
    end
    else if (init_act && unlk_q && wr && paddr == OFS_TIME)
    begin
      sec_q <= pwdata[6:0];
      min_q <= pwdata[14:8];
      hr_q  <= pwdata[21:16];
    end
    else if (init_act && unlk_q && wr && paddr == OFS_DATE)
    begin
      date_q <= pwdata[5:0];
      mon_q  <= pwdata[12:8];
      wday_q <= pwdata[15:13];
      yr_q   <= pwdata[23:16];
    end
    else if (run && unlk_q && wr && paddr == OFS_CTRL &&
             (pwdata[C_ADD_HOUR_BIT] || pwdata[C_SUBTRACT_HOUR_BIT]))
    begin
      // one-step hour move, stays within the same day
      if (pwdata[C_ADD_HOUR_BIT])
        hr_q <= (hr_q == 6'h23) ? 6'h0 : hr_up[5:0];
      else
        hr_q <= (hr_q == 6'h0) ? 6'h23 : hr_dn[5:0];
    end
    else if (spre)
    begin
      // calendar steps once per synchronous prescaler output, stopped while in init
      if (sec_q != 7'h59)
        sec_q <= sec_up[6:0];
      else
      begin
        sec_q <= 7'h0;
        if (min_q != 7'h59)
          min_q <= min_up[6:0];
        else
        begin
          min_q <= 7'h0;
          if (hr_q != 6'h23)
            hr_q <= hr_up[5:0];
          else
          begin
            hr_q   <= 6'h0;
            wday_q <= (wday_q == 3'h7) ? 3'h1 : wday_q + 3'h1;
            if (date_q != last_day(mon_q, yr_q))
              date_q <= date_up[5:0];
            else
            begin
              date_q <= 6'h01;
              if (mon_q != 5'h12)
                mon_q <= mon_up[4:0];
              else
              begin
                mon_q <= 5'h01;
                yr_q  <= (yr_q == 8'h99) ? 8'h0 : bcd_inc(yr_q);
              end
            end
          end
        end
      end
    end
  end

  logic [31:0] live_time, live_date;
  assign live_time = {10'h0, hr_q, 1'b0, min_q, 1'b0, sec_q};
  assign live_date = {8'h0, yr_q, wday_q, mon_q, 2'b0, date_q};

  // control register; hour steps are pulses and read back zero
  logic wut_wr_ok;
  assign wut_wr_ok = ~ctrl_q[C_WUE] & ~k2_q[2];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= 17'h0;
    else if (wr && paddr == OFS_CTRL && unlk_q)
    begin
      ctrl_q <= pwdata[16:0];
      ctrl_q[C_SUBTRACT_HOUR_BIT] <= 1'b0;
      ctrl_q[C_ADD_HOUR_BIT] <= 1'b0;
      if (!wut_wr_ok)
        ctrl_q[C_WSEL +: 3] <= ctrl_q[C_WSEL +: 3];
    end
  end

  // alarm registers
  logic [31:0] alm_q, almss_q;
  logic        wr_alm;
  assign wr_alm = wr && unlk_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alm_q   <= 32'h0;
      almss_q <= 32'h0;
    end
    else if (wr_alm && paddr == OFS_ALM)
      alm_q <= pwdata;
    else if (wr_alm && paddr == OFS_ALMSS)
      almss_q <= pwdata;
  end

  // field compare, each time field skipped when its mask bit is set; subseconds compared only when M_SS is set
  logic match, match_q, alm_hold_q, alm_set;
  assign match = (almss_q[M_SEC]   || alm_q[6:0]   == sec_q)  &&
                 (almss_q[M_SEC+1] || alm_q[14:8]  == min_q)  &&
                 (almss_q[M_SEC+2] || alm_q[21:16] == hr_q)   &&
                 (almss_q[M_SEC+3] || alm_q[29:24] == date_q) &&
                 (!almss_q[M_SS]   || almss_q[14:0] == scnt_q);
  // uses the third stage so the hold is already up when it opens
  assign alm_set = k3_q[1] & ~alm_hold_q & match & ~match_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_q    <= 1'b0;
      alm_hold_q <= 1'b0;
    end
    else
    begin
      match_q <= match;
      // a fresh enable waits until the next async prescaler output
      if (k2_q[1] && !k3_q[1] && kt)
        alm_hold_q <= 1'b1;
      else if (apre)
        alm_hold_q <= 1'b0;
    end
  end

  // wakeup timer: reload register and 17-bit down-counter
  logic [15:0] wrl_q;
  logic [16:0] wcnt_q, wload;
  logic [3:0]  wdiv_q, wmask;
  logic        wtick, wut_zero;
  assign wload = {ctrl_q[C_WSEL+2] & ctrl_q[C_WSEL+1], wrl_q};
  always_comb
  begin
    case (ctrl_q[C_WSEL +: 2])
      2'h0:    wmask = 4'h1;
      2'h1:    wmask = 4'h3;
      2'h2:    wmask = 4'h7;
      default: wmask = 4'hf;
    endcase
  end
  assign wtick = ctrl_q[C_WSEL+2] ? spre
               : kt & ((wdiv_q & wmask) == wmask);
  assign wut_zero = k2_q[2] & wtick & (wcnt_q == 17'h0);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wrl_q <= 16'hffff;
    else if (wr && unlk_q && paddr == OFS_WUT && wut_wr_ok)
      wrl_q <= pwdata[15:0];
  end
  // no system-reset term here, so the count runs on through it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdiv_q <= 4'h0;
      wcnt_q <= 17'h0;
    end
    else
    begin
      if (kt)
        wdiv_q <= wdiv_q + 4'h1;
      if (k2_q[2] && !k3_q[2])
        wcnt_q <= wload;
      else if (wut_zero)
        wcnt_q <= wload;
      else if (k2_q[2] && wtick)
        wcnt_q <= wcnt_q - 17'h1;
    end
  end

  // status flags: hardware set wins over a software clear
  logic alf_q, wuf_q, rsf_q;
  logic st_wr;
  assign st_wr = wr && paddr == OFS_STAT;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alf_q <= 1'b0;
      wuf_q <= 1'b0;
    end
    else
    begin
      alf_q <= alm_set | (alf_q & ~(st_wr & ~pwdata[S_ALF]));
      wuf_q <= wut_zero | (wuf_q & ~(st_wr & ~pwdata[S_WUF]));
    end
  end

  // shadow copies, cleared by system reset, frozen in halt
  logic [31:0] sh_time_q, sh_date_q;
  logic [14:0] sh_ss_q;
  logic        copy;
  assign copy = kt & ~halt & ~sys_rst;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sh_time_q <= 32'h0;
      sh_date_q <= 32'h0;
      sh_ss_q   <= 15'h0;
      rsf_q     <= 1'b0;
    end
    else if (sys_rst)
    begin
      sh_time_q <= 32'h0;
      sh_date_q <= 32'h0;
      sh_ss_q   <= 15'h0;
      rsf_q     <= 1'b0;
    end
    else
    begin
      if (copy)
      begin
        sh_time_q <= live_time;
        sh_date_q <= live_date;
        sh_ss_q   <= scnt_q;
      end
      rsf_q <= copy | (rsf_q & ~(st_wr & ~pwdata[S_RSF]));
    end
  end

  // read mux and response
  logic byp;
  assign byp = ctrl_q[C_BYP];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else
    begin
      pready_q  <= acc;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
      if (acc)
      begin
        if (paddr == OFS_TIME)
          prdata_q <= byp ? live_time : sh_time_q;
        else if (paddr == OFS_DATE)
          prdata_q <= byp ? live_date : sh_date_q;
        else if (paddr == OFS_SUBS)
          prdata_q <= {17'h0, byp ? scnt_q : sh_ss_q};
        else if (paddr == OFS_CTRL)
          prdata_q <= {15'h0, ctrl_q};
        else if (paddr == OFS_STAT)
          prdata_q <= {25'h0, wut_wr_ok, 1'b1, (yr_q != 8'h0),
                       init_act, rsf_q, wuf_q, alf_q};
        else if (paddr == OFS_PRE)
          prdata_q <= {1'b0, sdiv_q, 9'h0, adiv_q};
        else if (paddr == OFS_ALM)
          prdata_q <= alm_q;
        else if (paddr == OFS_ALMSS)
          prdata_q <= almss_q;
        else if (paddr == OFS_WUT)
          prdata_q <= {16'h0, wrl_q};
        else if (paddr == OFS_KEY)
          prdata_q <= 32'h0;
        else
          pslverr_q <= 1'b1;
      end
    end
  end

  // output pin and wake requests
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alarm_pin  <= 1'b0;
      alarm_irq  <= 1'b0;
      wakeup_irq <= 1'b0;
    end
    else
    begin
      alarm_irq  <= alf_q & ctrl_q[C_ALIE];
      wakeup_irq <= wuf_q & ctrl_q[C_WUIE];
      if (ctrl_q[C_OSEL +: 2] == OSEL_ALM)
        alarm_pin <= alf_q ^ ctrl_q[C_POL];
      else if (ctrl_q[C_OSEL +: 2] == OSEL_WUT)
        alarm_pin <= wuf_q ^ ctrl_q[C_POL];
      else
        alarm_pin <= ctrl_q[C_POL];
    end
  end
endmodule
`default_nettype wire

// >>> dv/rtc_chk.sv
// bus handshake and flag clearing checks for the real-time clock core
`timescale 1ns/100ps
`default_nettype none
module rtc_chk import rtc_pkg::*; (
  input wire logic        pclk,             // bus clock
  input wire logic        presetn,          // power-on reset, low
  input wire logic        psel,             // apb select
  input wire logic        penable,          // apb enable
  input wire logic        pwrite,           // apb write
  input wire logic [7:0]  paddr,            // apb address
  input wire logic [31:0] pwdata,           // apb write data
  input wire logic [31:0] prdata,           // apb read data
  input wire logic        pready,           // apb ready
  input wire logic        pslverr,          // apb error
  input wire logic        rtc_kernel_clock, // kernel clock pin
  input wire logic        sys_reset_n,      // system reset, low
  input wire logic        active_halt,      // halt state
  input wire logic        alarm_pin,        // alarm output pin
  input wire logic        alarm_irq,        // alarm wake request
  input wire logic        wakeup_irq        // wakeup wake request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic unmap; // address outside the aligned word map
  assign unmap = (paddr[1:0] != 2'h0) || (paddr > OFS_KEY);
  // access phase still waiting for its answer
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  // completed status write that clears flag bit b
  sequence s_clr(b);
    pready && pwrite && paddr == OFS_STAT && !pwdata[b];
  endsequence
  property p_wait; s_acc |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_idle; !(psel && penable) |=> !pready; endproperty
  property p_errrdy; pslverr |-> pready; endproperty
  property p_errmap; pready && unmap |-> pslverr; endproperty
  property p_okmap; pready && !unmap |-> !pslverr; endproperty
  property p_alclr; s_clr(S_ALF) |-> ##[1:4] !alarm_irq; endproperty
  property p_wuclr; s_clr(S_WUF) |-> ##[1:4] !wakeup_irq; endproperty
  a_wait: assert property (p_wait) else $error("no ready after access");
  a_one: assert property (p_one) else $error("ready longer than a cycle");
  a_idle: assert property (p_idle) else $error("ready without access");
  a_errrdy: assert property (p_errrdy) else $error("error without ready");
  a_errmap: assert property (p_errmap) else $error("unmapped not refused");
  a_okmap: assert property (p_okmap) else $error("mapped word refused");
  a_alclr: assert property (p_alclr) else $error("alarm irq stays");
  a_wuclr: assert property (p_wuclr) else $error("wakeup irq stays");
endmodule
bind rtc_core rtc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rtc_kernel_clock(rtc_kernel_clock), .sys_reset_n(sys_reset_n),
  .active_halt(active_halt), .alarm_pin(alarm_pin),
  .alarm_irq(alarm_irq), .wakeup_irq(wakeup_irq));
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the real-time clock core
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) check(g, x)
module tb;
  import rtc_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, t;
  logic        rtc_kernel_clock = 0, sys_reset_n = 1, active_halt = 0;
  logic        pready, pslverr, alarm_pin, alarm_irq, wakeup_irq, e, alarm_pin_polarity;
  logic [2:0]  kc = 0;        // kernel clock divider, 8 bus cycles a period
  logic [7:0]  s;             // alarm second
  int          err_total = 0, comparisons = 0, seed = 5740;
  int          r, n, c, c0, c1, cyc = 0;
  always #5 pclk = ~pclk;
  // kernel clock made from the bus clock so wakeup periods are exact
  always @(posedge pclk)
  begin
    kc <= kc + 3'h1;
    rtc_kernel_clock <= kc[2];
    cyc <= cyc + 1;
  end
  rtc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_kernel_clock(rtc_kernel_clock), .sys_reset_n(sys_reset_n),
    .active_halt(active_halt), .alarm_pin(alarm_pin),
    .alarm_irq(alarm_irq), .wakeup_irq(wakeup_irq));
  task check(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task conclude;
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one apb transfer; held until ready is seen at an edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20) err_total++;
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  // read until the masked bits show v, bounded
  task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do
    begin
      rd(a);
      k++;
    end
    while ((q & m) !== v && k < 300);
  endtask
  // wait for a wakeup request, return the cycle it was seen
  task rise(output int at);
    int k;
    k = 0;
    while (wakeup_irq !== 1'b1 && k < 3000)
    begin
      @(posedge pclk);
      k++;
    end
    at = cyc;
  endtask
  // bcd step of one field that wraps after m
  function automatic logic [7:0] b1(input logic [7:0] v, input logic [7:0] m);
    if (v == m) return 8'h00;
    if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
    return v + 8'h01;
  endfunction
  function automatic logic [31:0] nsec(input logic [31:0] x);
    logic [31:0] y;
    y = x;
    y[7:0] = b1(x[7:0], 8'h59);
    if (x[7:0] == 8'h59) y[15:8] = b1(x[15:8], 8'h59);
    if (x[15:0] == 16'h5959) y[23:16] = b1(x[23:16], 8'h23);
    return y;
  endfunction
  // bus cycles per wakeup period: kernel is 8 cycles, tick is 64
  function automatic int wper(input int sel, input int rl);
    return (sel < 4) ? 8 * (rl + 1) * (2 << sel) : 64 * (rl + 1);
  endfunction
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    rd(OFS_PRE);
    `CHK(q, 32'h00ff007f);
    rd(OFS_CTRL);
    `CHK(q, 32'h0);
    rd(OFS_STAT);
    `CHK({q[S_ALWF], q[S_INS]}, 2'h2);
    wr(OFS_PRE, 32'h00030001);
    rd(OFS_PRE);
    `CHK(q, 32'h00ff007f);
    rd(8'h30);
    `CHK(e, 1'b1);
    wr(OFS_KEY, {24'h0, KEY_1});
    wr(OFS_KEY, 32'h11);
    wr(OFS_CTRL, 32'h8);
    rd(OFS_CTRL);
    `CHK(q, 32'h0);
    wr(OFS_KEY, {24'h0, KEY_1});
    wr(OFS_KEY, {24'h0, KEY_2});
    wr(OFS_CTRL, 32'h3);
    poll(OFS_STAT, 32'h8, 32'h8);
    `CHK(q[S_INF], 1'b1);
    wr(OFS_PRE, 32'h00030001);
    wr(OFS_TIME, 32'h00235958);
    wr(OFS_DATE, 32'h00252228);
    wr(OFS_CTRL, 32'h2);
    rd(OFS_STAT);
    `CHK(q[S_INS], 1'b1);
    t = 32'h00235958;
    for (n = 0; n < 2; n++)
    begin
      c = 0;
      do
      begin
        rd(OFS_TIME);
        c++;
      end
      while (q === t && c < 300);
      t = nsec(t);
      `CHK(q, t);
    end
    rd(OFS_DATE);
    `CHK(q, 32'h00254301);
    wr(OFS_CTRL, 32'h8002);
    poll(OFS_TIME, 32'h003f0000, 32'h00010000);
    `CHK(q[23:16], 8'h01);
    wr(OFS_CTRL, 32'h14002);
    poll(OFS_TIME, 32'h003f0000, 32'h0);
    `CHK(q[23:16], 8'h00);
    rd(OFS_CTRL);
    `CHK(q, 32'h00010002);
    r = $random(seed);
    alarm_pin_polarity = r[0];
    rd(OFS_TIME);
    s = b1(b1(b1(q[7:0], 8'h59), 8'h59), 8'h59);
    wr(OFS_ALMSS, 32'h000e0000);
    wr(OFS_ALM, {24'h0, s});
    wr(OFS_CTRL, 32'h00010832 | {18'h0, alarm_pin_polarity, 13'h0});
    c = 0;
    while (alarm_irq !== 1'b1 && c < 1000)
    begin
      @(posedge pclk);
      c++;
    end
    rd(OFS_TIME);
    `CHK(q[7:0], s);
    `CHK(alarm_pin, !alarm_pin_polarity);
    rd(OFS_STAT);
    `CHK(q[S_ALF], 1'b1);
    wr(OFS_STAT, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(alarm_irq, 1'b0);
    // last pass runs with the sync_bypass_bit_a bit: every bus cycle is a kernel tick
    for (n = 0; n < 6; n++)
    begin
      c = (n == 5) ? 4 : 0;
      wr(OFS_CTRL, 32'h00011802 | c);
      poll(OFS_STAT, 32'h40, 32'h40);
      `CHK(q[S_WUWF], 1'b1);
      // a flag left from the last pass would fake the first rise
      wr(OFS_STAT, 32'h0);
      r = ($unsigned($random(seed)) % 4) + 1;
      wr(OFS_WUT, r);
      wr(OFS_CTRL, 32'h00011802 | (n << 8) | c);
      wr(OFS_CTRL, 32'h000118c2 | (n << 8) | c);
      rise(c0);
      wr(OFS_STAT, 32'h0);
      if (n == 2) sys_reset_n <= 0;
      repeat (6) @(posedge pclk);
      sys_reset_n <= 1;
      rise(c1);
      @(posedge pclk);
      `CHK(alarm_pin, 1'b1);
      t = (n == 5) ? 8 * (r + 1) : wper(n, r);
      `CHK(c1 - c0, t);
    end
    // shadow path: frozen in halt, cleared by system reset
    wr(OFS_CTRL, 32'h00010000);
    active_halt <= 1;
    repeat (20) @(posedge pclk);
    rd(OFS_TIME);
    t = q;
    repeat (200) @(posedge pclk);
    rd(OFS_TIME);
    `CHK(q, t);
    wr(OFS_CTRL, 32'h00010002);
    rd(OFS_TIME);
    `CHK(q === t, 1'b0);
    wr(OFS_CTRL, 32'h00010000);
    sys_reset_n <= 0;
    repeat (10) @(posedge pclk);
    sys_reset_n <= 1;
    repeat (10) @(posedge pclk);
    rd(OFS_TIME);
    `CHK(q, 32'h0);
    rd(OFS_STAT);
    `CHK(q[S_RSF], 1'b0);
    active_halt <= 0;
    poll(OFS_STAT, 32'h4, 32'h4);
    `CHK(q[S_RSF], 1'b1);
    conclude;
  end
  // cuts a hang short well beyond the expected run
  initial
  begin
    #400000;
    err_total++;
    conclude;
  end
endmodule
`default_nettype wire
